// ===== hdl/sspc_top.sv
// Synchronous serial port control core with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// [R1] Internal serial clock period is (reload + 1) x 2 system cycles.
// [R2] Software loads rate_reload with zero when the external clock is used.
// [R3] Shifter is not addressable; data passes through serial_holding.
// [R4] aux_rx_holding holds received bytes only in automatic full duplex.
// [R5] Wakeup bit 7 usable in mode 0; setting it forces automatic mode off.
// [R6] Bit 6 selects transmit when 0, receive when 1.
// [R7] Run bit starts transfer; clearing it aborts; software clears irq_enable too.
// [R8] Mode 0 and automatic transmit end at last rising clock; done set, run cleared.
// [R9] Automatic receive or duplex ends after last byte reaches RAM.
// [R10] Bit 4 selects mode 0 when 0, automatic mode 1 when 1.
// [R11] Clearing automatic bit mid transfer pauses after byte; setting it resumes.
// [R12] Software changes the automatic bit with whole-byte writes when idle.
// [R13] Bit 3 selects LSB first when 0, MSB first when 1.
// [R14] Overrun set on incoming clock falling edge while run is 0.
// [R15] Mode 0 overrun during startup and termination windows.
// [R16] Automatic transmit overrun before first byte is fetched and started.
// [R17] Automatic receive overrun from last rising edge until termination completes.
// [R18] Done set at transfer end; flags clear only by software write.
// [R19] Interrupt when irq_enable and done or overrun are set.
// [R20] Holding buffer is software accessible in mode 0, serviced from RAM in mode 1.
// [R21] Gap register sets interval, duplex and residual bit count.
// [R22] Gap code inserts 0,1,2,4,...,64 transfer clocks, mode 1 internal clock only.
// [R23] Gap cycles equal (reload + 1) x 2 times inserted clocks.
// [R24] Residual width code 0 means 8 bits, else the code value.
// [R25] Duplex bit selects automatic full duplex, valid only in mode 1.
// [R26] Data shifts out on falling edge, sampled on rising edge; clock idles high.
module sspc_top (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [16:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        sclkIn,
	output logic             sclkOut,
	output logic             sclkOe,
	input  wire logic        sdiIn,
	output logic             sdoOut,
	output logic             sdoOe,
	output logic             svcReq,
	output logic             svcWrite,
	output logic      [7:0]  svcWrData,
	input  wire logic        svcAck,
	input  wire logic [7:0]  svcRdData,
	input  wire logic        svcLast,
	output logic             irqOut
);
	// ------------------------------------------------------------
	// Decoders
	// ------------------------------------------------------------
	function automatic logic [3:0] widthOf(input logic [2:0] code);
		widthOf = (code == 3'h0) ? sspc_pkg::FULL_BYTE : {1'b0, code};
	endfunction : widthOf

	function automatic logic [7:0] gapTicks(input logic [2:0] code);
		logic [7:0] clocks;
		clocks = (code == 3'h0) ? 8'h00 : 8'(8'h01 << (code - 3'h1));
		gapTicks = 8'(clocks * 2);
	endfunction : gapTicks

	// ------------------------------------------------------------
	// Reset and pin synchronisers
	// ------------------------------------------------------------
	logic rstS1;
	logic rstN;
	logic sclkS1;
	logic sclkS2;
	logic sclkS3;
	logic sdiS1;
	logic sdiS2;
	logic [2:0] oeHistQ;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstS1 <= 1'b0;
			rstN  <= 1'b0;
		end
		else
		begin
			rstS1 <= 1'b1;
			rstN  <= rstS1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			sclkS1 <= 1'b1;
			sclkS2 <= 1'b1;
			sclkS3 <= 1'b1;
			sdiS1  <= 1'b0;
			sdiS2  <= 1'b0;
			oeHistQ <= 3'h0;
		end
		else
		begin
			sclkS1 <= sclkIn;
			sclkS2 <= sclkS1;
			sclkS3 <= sclkS2;
			sdiS1  <= sdiIn;
			sdiS2  <= sdiS1;
			oeHistQ <= {oeHistQ[1:0], sclkOe};
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] ctlQ, ctlD;
	logic [7:0] rateQ, rateD;
	logic [7:0] holdQ, holdD;
	logic [7:0] gapRegQ, gapRegD;
	logic [7:0] shiftQ, shiftD;
	logic [7:0] auxQ, auxD;
	logic [7:0] halfQ, halfD;
	logic [7:0] gapLeftQ, gapLeftD;
	logic [3:0] bitsQ, bitsD;
	logic       firstQ, firstD;
	logic       lastQ, lastD;
	logic       sclkQ, sclkD;
	logic       sdoQ, sdoD;
	logic       svcReqQ, svcReqD;
	logic       svcWrQ, svcWrD;
	logic [7:0] svcDataQ, svcDataD;
	logic [31:0] rdQ, rdD;
	logic       waitQ, waitD;
	sspc_pkg::sspc_state_t stQ, stD;

	logic        busReq;
	logic        wrTake;
	logic [14:0] idx;
	logic        extClk;
	logic        dividerOn;
	logic        tick;
	logic        fallEv;
	logic        riseEv;
	logic        pinFall;
	logic        autoOn;
	logic        duplex;
	logic        txFetch;
	logic        setDone;
	logic        setOvr;
	logic        clrRun;
	logic [7:0]  newShift;
	logic [3:0]  resWidth;

	always_comb
	begin
		busReq    = avs_read | avs_write;
		wrTake    = avs_write & ~waitQ;
		idx       = avs_address[16:2];
		extClk    = (rateQ == sspc_pkg::EXT_CLOCK); // [R2]
		autoOn    = ctlQ[sspc_pkg::CTL_AUTO]; // [R10]
		duplex    = gapRegQ[sspc_pkg::GAP_DUPLEX] & autoOn; // [R25]
		txFetch   = ~ctlQ[sspc_pkg::CTL_RX] | duplex; // [R6]
		resWidth  = widthOf(gapRegQ[6:4]); // [R24]
		dividerOn = ~extClk & ((stQ == sspc_pkg::ST_SHIFT) | (stQ == sspc_pkg::ST_GAP));
		tick      = dividerOn & (halfQ == 8'h00);
		// Our own clock echoes through the synchroniser; ignore it until drained
		pinFall   = sclkS3 & ~sclkS2 & ~sclkOe & (oeHistQ == 3'h0);
		if (extClk)
		begin
			fallEv = pinFall;
			riseEv = ~sclkS3 & sclkS2;
		end
		else
		begin
			fallEv = tick & sclkQ & (stQ == sspc_pkg::ST_SHIFT);
			riseEv = tick & ~sclkQ & (stQ == sspc_pkg::ST_SHIFT);
		end
		// LSB first shifts toward bit 0, MSB first toward bit 7
		if (ctlQ[sspc_pkg::CTL_MSB]) // [R13]
			newShift = {shiftQ[6:0], sdiS2};
		else
			newShift = {sdiS2, shiftQ[7:1]};
	end

	// ------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		stD      = stQ;
		shiftD   = shiftQ;
		auxD     = auxQ;
		bitsD    = bitsQ;
		firstD   = firstQ;
		lastD    = lastQ;
		sclkD    = sclkQ;
		sdoD     = sdoQ;
		svcReqD  = svcReqQ;
		svcWrD   = svcWrQ;
		svcDataD = svcDataQ;
		gapLeftD = gapLeftQ;
		holdD    = holdQ;
		setDone  = 1'b0;
		clrRun   = 1'b0;
		// Half period of n+1 cycles gives a full period of (n+1)*2
		halfD    = dividerOn ? (tick ? rateQ : 8'(halfQ - 8'h01)) : rateQ; // [R1]
		if (tick & (stQ == sspc_pkg::ST_SHIFT))
			sclkD = ~sclkQ;
		case (stQ)
			sspc_pkg::ST_IDLE:
			begin
				sclkD = 1'b1; // [R26]
				if (ctlQ[sspc_pkg::CTL_RUN]) // [R7]
					stD = sspc_pkg::ST_START;
			end
			sspc_pkg::ST_START:
			begin
				firstD = 1'b1;
				if (autoOn)
					stD = sspc_pkg::ST_LOAD;
				else
				begin
					shiftD = holdQ; // [R3]
					bitsD  = resWidth;
					lastD  = 1'b1;
					stD    = sspc_pkg::ST_SHIFT;
				end
			end
			sspc_pkg::ST_LOAD:
			begin
				if (txFetch)
				begin
					svcReqD = 1'b1; // [R20]
					svcWrD  = 1'b0;
					stD     = sspc_pkg::ST_FETCH;
				end
				else
				begin
					lastD = svcLast;
					bitsD = svcLast ? resWidth : sspc_pkg::FULL_BYTE;
					stD   = sspc_pkg::ST_SHIFT;
				end
			end
			sspc_pkg::ST_FETCH:
			begin
				if (svcAck)
				begin
					svcReqD = 1'b0;
					holdD   = svcRdData; // [R20]
					shiftD  = svcRdData;
					lastD   = svcLast;
					bitsD   = svcLast ? resWidth : sspc_pkg::FULL_BYTE;
					firstD  = 1'b0;
					stD     = sspc_pkg::ST_SHIFT;
				end
			end
			sspc_pkg::ST_SHIFT:
			begin
				if (fallEv)
					sdoD = ctlQ[sspc_pkg::CTL_MSB] ? shiftQ[7] : shiftQ[0]; // [R26]
				if (riseEv)
				begin
					shiftD = newShift; // [R26]
					bitsD  = 4'(bitsQ - 4'h1);
					if (bitsQ == 4'h1)
					begin
						sclkD = 1'b1;
						if (!autoOn & ~lastQ)
							stD = sspc_pkg::ST_NEXT;
						else if (!firstQ && !lastQ && ctlQ[sspc_pkg::CTL_RX] == 1'b0)
							stD = sspc_pkg::ST_NEXT;
						else if (ctlQ[sspc_pkg::CTL_RX] & (autoOn | ~lastQ))
						begin
							if (duplex)
								auxD = newShift; // [R4]
							else
								holdD = newShift;
							svcDataD = newShift;
							svcReqD  = 1'b1;
							svcWrD   = 1'b1;
							stD      = sspc_pkg::ST_STORE; // [R9]
						end
						else if (lastQ)
						begin
							if (ctlQ[sspc_pkg::CTL_RX])
								holdD = newShift;
							setDone = 1'b1; // [R8]
							clrRun  = 1'b1;
							stD     = sspc_pkg::ST_FINISH;
						end
						else
							stD = sspc_pkg::ST_NEXT;
					end
				end
			end
			sspc_pkg::ST_STORE:
			begin
				if (svcAck)
				begin
					svcReqD = 1'b0;
					svcWrD  = 1'b0;
					firstD  = 1'b0;
					if (lastQ)
					begin
						setDone = 1'b1; // [R9]
						clrRun  = 1'b1;
						stD     = sspc_pkg::ST_FINISH;
					end
					else
						stD = sspc_pkg::ST_NEXT;
				end
			end
			sspc_pkg::ST_NEXT, sspc_pkg::ST_PAUSE:
			begin
				// Pause keeps run high and done low until automatic mode returns
				if (!autoOn)
					stD = sspc_pkg::ST_PAUSE; // [R11]
				else if (!extClk && gapRegQ[2:0] != 3'h0)
				begin
					gapLeftD = 8'(gapTicks(gapRegQ[2:0]) - 8'h01); // [R22]
					stD      = sspc_pkg::ST_GAP;
				end
				else
					stD = sspc_pkg::ST_LOAD;
			end
			sspc_pkg::ST_GAP:
			begin
				// Two divider ticks per inserted transfer clock
				if (tick)
				begin
					gapLeftD = 8'(gapLeftQ - 8'h01); // [R23]
					if (gapLeftQ == 8'h00)
						stD = sspc_pkg::ST_LOAD;
				end
			end
			sspc_pkg::ST_FINISH:
				stD = sspc_pkg::ST_IDLE;
			default:
				stD = sspc_pkg::ST_IDLE;
		endcase
		// Software clearing run aborts whatever is in flight
		if (!ctlQ[sspc_pkg::CTL_RUN] && stQ != sspc_pkg::ST_IDLE && stQ != sspc_pkg::ST_FINISH)
		begin
			stD     = sspc_pkg::ST_IDLE; // [R7]
			svcReqD = 1'b0;
			svcWrD  = 1'b0;
			sclkD   = 1'b1;
		end
		// Software may load the holding buffer directly in mode 0
		if (wrTake && idx == sspc_pkg::IDX_HOLDING)
			holdD = avs_writedata[7:0]; // [R20]
		setOvr = pinFall & (~ctlQ[sspc_pkg::CTL_RUN] // [R14]
			| (extClk & ((stQ == sspc_pkg::ST_START) | (stQ == sspc_pkg::ST_FINISH))) // [R15]
			| (extClk & (stQ == sspc_pkg::ST_FETCH) & firstQ) // [R16]
			| (extClk & (stQ == sspc_pkg::ST_STORE) & lastQ)); // [R17]
	end

	// ------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------
	always_comb
	begin
		ctlD    = ctlQ;
		rateD   = rateQ;
		gapRegD = gapRegQ;
		rdD     = rdQ;
		waitD   = ~(busReq & waitQ);
		if (avs_read & waitQ)
		begin
			case (idx)
				sspc_pkg::IDX_CONTROL: rdD = {24'h000000, ctlQ};
				sspc_pkg::IDX_RATE:    rdD = {24'h000000, rateQ};
				sspc_pkg::IDX_HOLDING: rdD = {24'h000000, holdQ};
				sspc_pkg::IDX_GAP:     rdD = {24'h000000, gapRegQ};
				default:               rdD = 32'h00000000;
			endcase
		end
		if (wrTake)
		begin
			case (idx)
				sspc_pkg::IDX_CONTROL:
				begin
					ctlD = avs_writedata[7:0];
					if (avs_writedata[sspc_pkg::CTL_WAKEUP])
						ctlD[sspc_pkg::CTL_AUTO] = 1'b0; // [R5]
				end
				sspc_pkg::IDX_RATE: rateD = avs_writedata[7:0];
				sspc_pkg::IDX_GAP:  gapRegD = {1'b0, avs_writedata[6:0]}; // [R21]
				default: ;
			endcase
		end
		if (clrRun)
			ctlD[sspc_pkg::CTL_RUN] = 1'b0; // [R8]
		// Hardware set wins over a software clear in the same cycle
		if (setDone)
			ctlD[sspc_pkg::CTL_DONE] = 1'b1; // [R18]
		if (setOvr)
			ctlD[sspc_pkg::CTL_OVR] = 1'b1; // [R18]
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			stQ      <= sspc_pkg::ST_IDLE;
			ctlQ     <= sspc_pkg::RST_CONTROL;
			rateQ    <= sspc_pkg::RST_RATE;
			holdQ    <= sspc_pkg::RST_HOLDING;
			gapRegQ  <= sspc_pkg::RST_GAP;
			shiftQ   <= 8'h00;
			auxQ     <= 8'h00;
			halfQ    <= 8'h00;
			gapLeftQ <= 8'h00;
			bitsQ    <= 4'h0;
			firstQ   <= 1'b0;
			lastQ    <= 1'b0;
			sclkQ    <= 1'b1;
			sdoQ     <= 1'b1;
			svcReqQ  <= 1'b0;
			svcWrQ   <= 1'b0;
			svcDataQ <= 8'h00;
			rdQ      <= 32'h00000000;
			waitQ    <= 1'b1;
			sclkOe   <= 1'b0;
			sdoOe    <= 1'b0;
			irqOut   <= 1'b0;
		end
		else
		begin
			stQ      <= stD;
			ctlQ     <= ctlD;
			rateQ    <= rateD;
			holdQ    <= holdD;
			gapRegQ  <= gapRegD;
			shiftQ   <= shiftD;
			auxQ     <= auxD;
			halfQ    <= halfD;
			gapLeftQ <= gapLeftD;
			bitsQ    <= bitsD;
			firstQ   <= firstD;
			lastQ    <= lastD;
			sclkQ    <= sclkD;
			sdoQ     <= sdoD;
			svcReqQ  <= svcReqD;
			svcWrQ   <= svcWrD;
			svcDataQ <= svcDataD;
			rdQ      <= rdD;
			waitQ    <= waitD;
			// Keep driving until the clock is back high after an abort
			sclkOe   <= ~extClk & (ctlD[sspc_pkg::CTL_RUN] | ~sclkD);
			sdoOe    <= ctlD[sspc_pkg::CTL_RUN] & ~(ctlD[sspc_pkg::CTL_AUTO]
				& ctlD[sspc_pkg::CTL_RX] & ~gapRegD[sspc_pkg::GAP_DUPLEX]);
			irqOut   <= ctlD[sspc_pkg::CTL_IE]
				& (ctlD[sspc_pkg::CTL_DONE] | ctlD[sspc_pkg::CTL_OVR]); // [R19]
		end
	end

	assign avs_readdata    = rdQ;
	assign avs_waitrequest = waitQ;
	assign sclkOut         = sclkQ;
	assign sdoOut          = sdoQ;
	assign svcReq          = svcReqQ;
	assign svcWrite        = svcWrQ;
	assign svcWrData       = svcDataQ;
endmodule : sspc_top
`default_nettype wire

// ===== hdl/sspc_pkg.sv
// Constants shared by the synchronous serial port control core
package sspc_pkg;
	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam int          IDX_W           = 15;
	localparam logic [14:0] IDX_CONTROL     = 15'h7f34;
	localparam logic [14:0] IDX_RATE        = 15'h7f35;
	localparam logic [14:0] IDX_HOLDING     = 15'h7f36;
	localparam logic [14:0] IDX_GAP         = 15'h7f37;

	// ------------------------------------------------------------
	// serial_control field positions
	// ------------------------------------------------------------
	localparam int CTL_WAKEUP = 7;
	localparam int CTL_RX     = 6;
	localparam int CTL_RUN    = 5;
	localparam int CTL_AUTO   = 4;
	localparam int CTL_MSB    = 3;
	localparam int CTL_OVR    = 2;
	localparam int CTL_DONE   = 1;
	localparam int CTL_IE     = 0;

	// ------------------------------------------------------------
	// gap_select_register field positions
	// ------------------------------------------------------------
	localparam int GAP_RES_LSB = 4;
	localparam int GAP_DUPLEX  = 3;
	localparam int GAP_SEL_LSB = 0;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_RATE    = 8'h00;
	localparam logic [7:0] RST_HOLDING = 8'h00;
	localparam logic [7:0] RST_GAP     = 8'h00;
	localparam logic [3:0] FULL_BYTE   = 4'h8;
	localparam logic [7:0] EXT_CLOCK   = 8'h00;
	localparam int         RATE_MULT   = 2;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_START,
		ST_LOAD,
		ST_FETCH,
		ST_SHIFT,
		ST_STORE,
		ST_NEXT,
		ST_GAP,
		ST_PAUSE,
		ST_FINISH
	} sspc_state_t;
endpackage : sspc_pkg

// ===== verification/sspc_chk.sv
// Concurrent checks on the ports of the serial port control core
`timescale 1ns/1ps
`default_nettype none
module sspc_chk (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic sclkOut,
	input wire logic sclkOe,
	input wire logic sdoOut,
	input wire logic svcReq,
	input wire logic svcAck
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// Register bus handshake
	// ------------------------------------------------------------
	sequence sBusReq;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence sBusAns;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_bus_answer: assert property (sBusReq |=> sBusAns)
		else $error("bus answer not after one wait cycle");
	a_wait_rises: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	// ------------------------------------------------------------
	// Serial clock and data
	// ------------------------------------------------------------
	a_clk_idle: assert property (!sclkOe |-> sclkOut)
		else $error("serial clock not high while undriven");
	a_fall_driven: assert property ($fell(sclkOut) |-> sclkOe)
		else $error("serial clock fell while not driven");
	a_low_half: assert property ($fell(sclkOut) |=> !sclkOut || !sclkOe)
		else $error("serial clock low phase too short");
	a_high_half: assert property (sclkOe && $rose(sclkOut) |=> sclkOut || !sclkOe)
		else $error("serial clock high phase too short");
	a_sdo_at_rise: assert property (sclkOe && $rose(sclkOut) |-> $stable(sdoOut))
		else $error("data changed at rising serial clock");

	// ------------------------------------------------------------
	// Service port
	// ------------------------------------------------------------
	sequence sSvcWait;
		svcReq && !svcAck;
	endsequence
	a_svc_hold: assert property (sSvcWait |=> svcReq)
		else $error("service request dropped before ack");
	a_svc_release: assert property (svcAck && svcReq |=> !svcReq)
		else $error("service request held after ack");
	c_svc_ack: cover property (svcAck && svcReq);
endmodule : sspc_chk
`default_nettype wire

// ===== verification/sspc_peer.sv
// External synchronous serial peer model
`timescale 1ns/1ps
`default_nettype none
module sspc_peer (
	input  wire logic        sclkOut,
	input  wire logic        sclkOe,
	input  wire logic        sdoOut,
	input  wire logic [7:0]  txByte,
	output logic             sclkLine,
	output logic             sdiLine,
	output logic      [15:0] capWord
);
	logic       extClk;
	logic [7:0] txShift;
	logic       lastBit;

	initial
	begin
		extClk = 1'b1;
		txShift = 8'h00;
		lastBit = 1'b0;
		capWord = 16'h0000;
	end

	// Our own clock idles high and runs only within bursts
	assign sclkLine = sclkOe ? sclkOut : extClk;
	// Outside transfers the line flips, so a stale bit never reads as data
	assign sdiLine = (sclkOe || !extClk) ? lastBit : !lastBit;

	always @(posedge sclkOe) txShift <= txByte;
	always @(negedge sclkLine)
	begin
		lastBit <= txShift[7];
		txShift <= {txShift[6:0], 1'b0};
	end
	always @(posedge sclkLine) capWord <= {capWord[14:0], sdoOut};

	task automatic extBurst(input int n);
		repeat (n)
		begin
			#200 extClk = 1'b0;
			#200 extClk = 1'b1;
		end
	endtask : extBurst
endmodule : sspc_peer
`default_nettype wire

// ===== verification/sspc_top_test.sv
// Self-checking bench for the serial port control core
`timescale 1ns/1ps
`default_nettype none
module sspc_top_test;
	logic        ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [16:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic        sclkLine, sclkOut, sclkOe, sdiLine, sdoOut, sdoOe;
	logic        svcReq, svcWrite, irqOut;
	logic        svcAck = 1'b0;
	logic        svcLast = 1'b0;
	logic [7:0]  svcWrData, peerTx, rdv;
	logic [7:0]  svcRdData = 8'h00;
	logic [15:0] capWord;
	int          nMismatch, nCompared;
	int          nFetch = 0;

	sspc_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sclkIn(sclkLine), .sclkOut(sclkOut), .sclkOe(sclkOe), .sdiIn(sdiLine),
		.sdoOut(sdoOut), .sdoOe(sdoOe), .svcReq(svcReq), .svcWrite(svcWrite),
		.svcWrData(svcWrData), .svcAck(svcAck), .svcRdData(svcRdData),
		.svcLast(svcLast), .irqOut(irqOut));
	sspc_peer peer (.sclkOut(sclkOut), .sclkOe(sclkOe), .sdoOut(sdoOut), .txByte(peerTx),
		.sclkLine(sclkLine), .sdiLine(sdiLine), .capWord(capWord));

	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// RAM service: answers one cycle late, second byte is the last
	// ------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		svcAck <= svcReq && !svcAck;
		svcRdData <= (nFetch == 0) ? 8'h3c : 8'hc3;
		svcLast <= (nFetch == 1);
		if (svcAck && svcReq && !svcWrite)
			nFetch <= nFetch + 1;
	end

	// ------------------------------------------------------------
	// Bus tasks and comparisons
	// ------------------------------------------------------------
	task automatic bus(input logic wr, input logic [14:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge ref_clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h000000, wd};
		// Request holds until waitrequest is seen low at a rising edge
		do
			@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [14:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkByte

	task automatic chkBit(input logic got, input logic exp);
		nCompared++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("CHECK FAILED %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chkBit

	task automatic waitIdle;
		logic [7:0] v;
		int i;
		v = 8'hff;
		i = 0;
		while (v[5] !== 1'b0 && i < 300)
		begin
			repeat (4) @(posedge ref_clk);
			bus(1'b0, sspc_pkg::IDX_CONTROL, 8'h00, v);
			i++;
		end
		if (i >= 300)
		begin
			nMismatch++;
			$display("CHECK FAILED %0t: transfer never ended", $time);
		end
	endtask : waitIdle

	task automatic summarize;
		$display("Compared %0d, mismatches %0d", nCompared, nMismatch);
		if (nMismatch == 0 && nCompared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	initial
	begin
		#1000000;
		nMismatch++;
		$display("CHECK FAILED %0t: watchdog expired", $time);
		summarize();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		reset_n = 1'b0;
		avs_address = 17'h00000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		peerTx = 8'h00;
		nMismatch = 0;
		nCompared = 0;
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, sspc_pkg::IDX_CONTROL + 15'(i), 8'h00, rdv);
			chkByte(rdv, 8'h00);
		end
		// Unmapped index ignores writes
		wr(15'h7f38, 8'hff);
		bus(1'b0, 15'h7f38, 8'h00, rdv);
		chkByte(rdv, 8'h00);
		wr(sspc_pkg::IDX_RATE, 8'ha5);
		bus(1'b0, sspc_pkg::IDX_RATE, 8'h00, rdv);
		chkByte(rdv, 8'ha5);
		wr(sspc_pkg::IDX_GAP, 8'hff);
		bus(1'b0, sspc_pkg::IDX_GAP, 8'h00, rdv);
		chkByte(rdv, 8'h7f);
		wr(sspc_pkg::IDX_CONTROL, 8'h90);
		bus(1'b0, sspc_pkg::IDX_CONTROL, 8'h00, rdv);
		chkByte(rdv, 8'h80);
		// Mode 0 send, MSB first, eight bits
		wr(sspc_pkg::IDX_RATE, 8'h01);
		wr(sspc_pkg::IDX_GAP, 8'h00);
		wr(sspc_pkg::IDX_HOLDING, 8'ha5);
		wr(sspc_pkg::IDX_CONTROL, 8'h28);
		waitIdle();
		chkByte(capWord[7:0], 8'ha5);
		bus(1'b0, sspc_pkg::IDX_CONTROL, 8'h00, rdv);
		chkByte(rdv, 8'h0a);
		wr(sspc_pkg::IDX_CONTROL, 8'h0b);
		repeat (3) @(posedge ref_clk);
		chkBit(irqOut, 1'b1);
		wr(sspc_pkg::IDX_CONTROL, 8'h09);
		repeat (3) @(posedge ref_clk);
		chkBit(irqOut, 1'b0);
		// Mode 0 receive, LSB first, five bits; unfilled low bits start cleared
		peerTx <= 8'hd8;
		wr(sspc_pkg::IDX_HOLDING, 8'h00);
		wr(sspc_pkg::IDX_RATE, 8'h03);
		wr(sspc_pkg::IDX_GAP, 8'h50);
		wr(sspc_pkg::IDX_CONTROL, 8'h60);
		waitIdle();
		bus(1'b0, sspc_pkg::IDX_HOLDING, 8'h00, rdv);
		chkByte(rdv, 8'hd8);
		bus(1'b0, sspc_pkg::IDX_CONTROL, 8'h00, rdv);
		chkByte(rdv, 8'h42);
		// Stray external clock while stopped
		wr(sspc_pkg::IDX_CONTROL, 8'h00);
		wr(sspc_pkg::IDX_RATE, 8'h00);
		peer.extBurst(2);
		repeat (8) @(posedge ref_clk);
		bus(1'b0, sspc_pkg::IDX_CONTROL, 8'h00, rdv);
		chkByte(rdv, 8'h04);
		bus(1'b0, sspc_pkg::IDX_CONTROL, 8'h00, rdv);
		chkByte(rdv, 8'h04);
		wr(sspc_pkg::IDX_CONTROL, 8'h05);
		repeat (3) @(posedge ref_clk);
		chkBit(irqOut, 1'b1);
		// Automatic send of two bytes from RAM
		wr(sspc_pkg::IDX_CONTROL, 8'h00);
		wr(sspc_pkg::IDX_RATE, 8'h01);
		wr(sspc_pkg::IDX_GAP, 8'h00);
		wr(sspc_pkg::IDX_CONTROL, 8'h38);
		waitIdle();
		chkByte(capWord[15:8], 8'h3c);
		chkByte(capWord[7:0], 8'hc3);
		chkByte(8'(nFetch), 8'h02);
		bus(1'b0, sspc_pkg::IDX_CONTROL, 8'h00, rdv);
		chkByte(rdv, 8'h1a);
		// Abort a slow mode 0 send long before its first clock edge
		wr(sspc_pkg::IDX_RATE, 8'hff);
		wr(sspc_pkg::IDX_CONTROL, 8'h20);
		repeat (2) @(posedge ref_clk);
		chkBit(sclkOe, 1'b1);
		chkBit(sdoOe, 1'b1);
		wr(sspc_pkg::IDX_CONTROL, 8'h00);
		repeat (600) @(posedge ref_clk);
		chkBit(sclkOe, 1'b0);
		bus(1'b0, sspc_pkg::IDX_CONTROL, 8'h00, rdv);
		chkByte(rdv, 8'h00);
		summarize();
	end
endmodule : sspc_top_test

bind sspc_top sspc_chk chk (.ref_clk(ref_clk), .reset_n(reset_n), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .sclkOut(sclkOut),
	.sclkOe(sclkOe), .sdoOut(sdoOut), .svcReq(svcReq), .svcAck(svcAck));
`default_nettype wire
